// ===== design/pwcd_pkg.sv
// shared constants, types and carriers for the wiper command decoder
package pwcd_pkg;

   // memory map of the command-byte address field
   localparam logic [3:0] ADDR_WIPER0 = 4'h0; // wiper_zero_setting
   localparam logic [3:0] ADDR_WIPER1 = 4'h1; // wiper_one_setting
   localparam logic [3:0] ADDR_TERM = 4'h4; // terminal_connection_control
   localparam logic [3:0] ADDR_STATUS = 4'h5; // status_mirror, read only

   // bit slot positions inside one nine-clock byte frame
   localparam logic [3:0] BIT_FIRST = 4'h0; // first data bit of a byte
   localparam logic [3:0] BIT_LAST = 4'h7; // eighth data bit
   localparam logic [3:0] BIT_ACK = 4'h8; // acknowledge slot
   localparam logic [3:0] BIT_STEP = 4'h1; // slot advance

   // control and read byte layout
   localparam int unsigned CTRL_RW_BIT = 0; // read/write select
   localparam int unsigned TX_MSB = 7; // first bit sent on a read byte

   // wiper value limits
   localparam logic [8:0] WIPER_MAX_257 = 9'h100; // full scale, 257 steps
   localparam logic [8:0] WIPER_MAX_129 = 9'h080; // full scale, 129 steps
   localparam logic [8:0] WIPER_ZERO = 9'h000; // zero scale
   localparam logic [8:0] WIPER_ONE = 9'h001; // one step
   localparam logic [6:0] READ_HI_PAD = 7'h00; // unused bits of high read byte

   // status_mirror field positions
   localparam int unsigned STATUS_HV_LEVEL_BIT = 0; // live high voltage level
   localparam int unsigned STATUS_HV_CMD_BIT = 1; // last command was high voltage

   // strap catch delay after reset release, covers the synchroniser
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // operation code field encoding
   typedef enum logic [1:0] {
      OP_WRITE = 2'h0,
      OP_INC = 2'h1,
      OP_DEC = 2'h2,
      OP_READ = 2'h3
   } pwcd_op_t;

   // command byte carrier, msb first as it arrives on the wire
   typedef struct packed {
      logic [3:0] memory_address_field; // bits 7..4
      pwcd_op_t operation_code_field; // bits 3..2
      logic spare_data_bit; // bit 1, no effect
      logic wiper_top_data_bit; // bit 0, value bit 8
   } pwcd_cmd_t;

   // one-hot protocol states
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01, // bus free, waiting for start
      ST_CTRL = 8'h02, // receiving control byte
      ST_CMD = 8'h04, // receiving command byte
      ST_DATA = 8'h08, // receiving write data byte
      ST_TX_HI = 8'h10, // sending high read byte
      ST_TX_LO = 8'h20, // sending low read byte
      ST_LOCK = 8'h40, // error lockout until start
      ST_SKIP = 8'h80 // not for us or read ended
   } pwcd_state_t;

endpackage

// ===== design/pwcd_decoder.sv
// wiper command decoder behind the two-wire serial pins
// Function
// - command byte: address, operation, two data bits
// - operation selects read, write, increment, decrement
// - increment/decrement valid only at wipers 0, 1
// - increment/decrement at 04h-0Fh are invalid
// - valid pair: drive acknowledge after command
// - invalid pair: leave acknowledge slot released
// - after error ignore all until start
// - nine bit storage, extra bits ignored
// - upper command data bit unused on writes
// - read returns two bytes, high first
// - write value: command bit above data byte
// - wiper top bit source depends on step count
// - full scale values accepted on 257 steps
// - only read and write carry data bytes
// - stop or restart mid byte aborts
// - master frames bytes, device drives acknowledges of the addressed and valid bytes it receives
// - update during acknowledge after data byte
// - continuous command plus data pairs allowed
// - high voltage level selects command variant
// - increment saturates at full scale
// - decrement saturates at zero
// - pointer resets to zero, survives stop
`timescale 1ns/1ps

module pwcd_decoder
   import pwcd_pkg::*;
#(
   parameter logic STEPS_257 = 1'b1, // 1: 257-step part, 0: 129-step part
   parameter logic [5:0] SLAVE_ADDR_HI = 6'h17, // control byte bits 7..2
   parameter logic [8:0] WIPER_RESET = 9'h080, // wiper value after reset
   parameter logic [8:0] TERM_RESET = 9'h1ff // terminal control after reset
) (
   input wire logic mclk_in, // core clock
   input wire logic reset_in, // synchronous, active high
   input wire logic link_scl_clk_in, // serial clock from the master
   input wire logic sda_in, // serial data level on the wire
   output logic sda_out, // open drain data, always low
   output logic sda_oe_out, // high while pulling data low
   input wire logic lowest_address_select_in, // address strap level
   input wire logic high_voltage_indicator_in, // high voltage sensed on strap pin
   output logic [8:0] wiper_zero_setting_out, // wiper 0 value
   output logic [8:0] wiper_one_setting_out, // wiper 1 value
   output logic [8:0] terminal_connection_control_out, // terminal control value
   output logic high_voltage_active_out, // synchronised high voltage level
   output logic hv_command_out, // last accepted command was high voltage
   output logic error_lockout_out // locked out after an invalid command
);

   // all core-domain state in one record
   typedef struct packed {
      logic scl_m, scl_s, scl_p; // clock level: two sync stages, then one cycle older
      logic sda_m, sda_s, sda_p; // data level: two sync stages, then one cycle older
      logic hv_m, hv_s; // high voltage level, two sync stages
      logic sel_m, sel_s; // strap level, two sync stages
      logic [1:0] strap_cnt; // wait before catching the strap
      logic strap_done; // strap has been caught
      logic addr_lsb; // caught strap, low slave address bit
      pwcd_state_t st; // protocol state
      logic [3:0] cnt; // bit slot inside the byte
      logic [7:0] shreg; // receive or transmit shifter
      logic rw; // control byte read select
      pwcd_cmd_t cmd; // last accepted command
      logic [3:0] ptr; // memory address pointer
      logic oe; // data pull-down enable
      logic [8:0] wip0; // wiper_zero_setting
      logic [8:0] wip1; // wiper_one_setting
      logic [8:0] term; // terminal_connection_control
      logic hv_cmd; // high voltage variant taken
   } pwcd_core_t;

   localparam pwcd_core_t CORE_RESET = '{
      scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, // idle high
      st: ST_IDLE,
      wip0: WIPER_RESET,
      wip1: WIPER_RESET,
      term: TERM_RESET,
      default: '0
   };

   // link-domain record: one data bit caught on the serial clock
   typedef struct packed {
      logic bit_val; // data level at the last rising serial clock
   } pwcd_link_t;
   pwcd_core_t q, d; // core state and its next value
   pwcd_link_t lnk_q, lnk_d; // link state and its next value
   logic rise_ev, fall_ev; // serial clock edges seen in the core domain
   logic start_ev, stop_ev; // start or repeated start; stop
   logic [8:0] wmax; // saturation limit of this part
   logic cmd_done, cmd_ok; // command byte complete; and it is a valid pair
   logic inc_fire, dec_fire, wr_fire; // increment, decrement, write take effect
   logic [8:0] wr_wiper, wr_raw; // value for a wiper; value for terminal control
   logic [8:0] rd_word; // word at the pointer for reads
   pwcd_cmd_t rx_cmd; // received byte viewed as a command

   // address and operation pair check
   function automatic logic cmd_valid(input pwcd_cmd_t c);
      logic ok;
      logic wiper;
      logic [3:0] a;
      ok = 1'b0;
      a = c.memory_address_field;
      wiper = (a == ADDR_WIPER0) || (a == ADDR_WIPER1);
      case (c.operation_code_field)
         OP_WRITE: ok = wiper || (a == ADDR_TERM);
         OP_READ: ok = wiper || (a == ADDR_TERM) || (a == ADDR_STATUS);
         // only the two wipers step; 04h and up are refused
         OP_INC, OP_DEC: ok = wiper;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // saturating step or plain load of one wiper
   function automatic logic [8:0] wiper_next(input logic [8:0] v, input logic up, input logic dn,
      input logic wr, input logic [8:0] wv, input logic [8:0] mx);
      logic [8:0] n;
      n = v;
      if (wr) begin
         n = wv;
      end else if (up && (v < mx)) begin
         n = v + WIPER_ONE;
      end else if (dn && (v != WIPER_ZERO)) begin
         n = v - WIPER_ONE;
      end
      return n;
   endfunction

   // link domain: catch data on each rising serial clock
   // the bit stays put while the clock is high, long enough for the core to read it
   always_comb begin
      lnk_d = lnk_q;
      lnk_d.bit_val = sda_in;
   end

   // link register, no reset: the clock may not run then; its value is data only
   always_ff @(posedge link_scl_clk_in) begin
      lnk_q <= lnk_d;
   end

   // bus events from the synchronised levels
   always_comb begin
      rise_ev = q.scl_s & ~q.scl_p;
      fall_ev = ~q.scl_s & q.scl_p;
      // data edges while the clock stays high frame the transfers
      start_ev = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
      stop_ev = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
      wmax = STEPS_257 ? WIPER_MAX_257 : WIPER_MAX_129;
      rx_cmd = pwcd_cmd_t'(q.shreg);
      // spare bit never looked at; top bit always kept for terminal control, for wipers only on 257-step parts
      wr_raw = {q.cmd.wiper_top_data_bit, q.shreg};
      wr_wiper = STEPS_257 ? wr_raw : {1'b0, q.shreg};
      case (q.ptr)
         ADDR_WIPER0: rd_word = q.wip0;
         ADDR_WIPER1: rd_word = q.wip1;
         ADDR_TERM: rd_word = q.term;
         ADDR_STATUS: begin
            rd_word = WIPER_ZERO;
            rd_word[STATUS_HV_LEVEL_BIT] = q.hv_s;
            rd_word[STATUS_HV_CMD_BIT] = q.hv_cmd;
         end
         default: rd_word = WIPER_ZERO;
      endcase
   end

   // core next state
   always_comb begin
      d = q;
      cmd_done = 1'b0;
      cmd_ok = 1'b0;
      inc_fire = 1'b0;
      dec_fire = 1'b0;
      wr_fire = 1'b0;
      // two-stage synchronisers on every pin level
      d.scl_m = link_scl_clk_in;
      d.scl_s = q.scl_m;
      d.scl_p = q.scl_s;
      d.sda_m = sda_in;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      d.hv_m = high_voltage_indicator_in;
      d.hv_s = q.hv_m;
      d.sel_m = lowest_address_select_in;
      d.sel_s = q.sel_m;
      // strap caught once after release, once the synchroniser is full
      if (!q.strap_done) begin
         d.strap_cnt = q.strap_cnt + 2'h1;
         if (q.strap_cnt == STRAP_WAIT) begin
            d.strap_done = 1'b1;
            d.addr_lsb = q.sel_s;
         end
      end
      if (start_ev) begin
         // start resets the byte engine and clears the lockout
         d.st = ST_CTRL;
         d.cnt = BIT_FIRST - BIT_STEP; // the fall closing the start is no bit slot
         d.oe = 1'b0;
      end else if (stop_ev) begin
         // stop mid byte drops the sequence; lockout survives a stop
         if (q.st != ST_LOCK) begin
            d.st = ST_IDLE;
         end
         d.cnt = BIT_FIRST;
         d.oe = 1'b0;
      end else begin
         case (q.st)
            ST_CTRL: begin
               if (rise_ev && (q.cnt != BIT_ACK)) begin
                  d.shreg = {q.shreg[6:0], lnk_q.bit_val};
               end
               if (fall_ev) begin
                  if (q.cnt == BIT_LAST) begin
                     d.cnt = BIT_ACK;
                     d.rw = q.shreg[CTRL_RW_BIT];
                     if (q.shreg[7:1] == {SLAVE_ADDR_HI, q.addr_lsb}) begin
                        d.oe = 1'b1;
                     end else begin
                        d.st = ST_SKIP;
                     end
                  end else if (q.cnt == BIT_ACK) begin
                     d.cnt = BIT_FIRST;
                     if (q.rw) begin
                        // first read bit goes out as the ack slot ends
                        d.st = ST_TX_HI;
                        d.shreg = {READ_HI_PAD, rd_word[8]};
                        d.oe = ~d.shreg[TX_MSB];
                     end else begin
                        d.st = ST_CMD;
                        d.oe = 1'b0;
                     end
                  end else begin
                     d.cnt = q.cnt + BIT_STEP;
                  end
               end
            end
            ST_CMD: begin
               if (rise_ev && (q.cnt != BIT_ACK)) begin
                  d.shreg = {q.shreg[6:0], lnk_q.bit_val};
               end else if (rise_ev) begin
                  // steps take effect inside the command acknowledge clock
                  inc_fire = (q.cmd.operation_code_field == OP_INC);
                  dec_fire = (q.cmd.operation_code_field == OP_DEC);
               end
               if (fall_ev) begin
                  if (q.cnt == BIT_LAST) begin
                     d.cnt = BIT_ACK;
                     cmd_done = 1'b1;
                     cmd_ok = cmd_valid(rx_cmd);
                     if (cmd_ok) begin
                        d.oe = 1'b1;
                        d.cmd = rx_cmd;
                        d.ptr = rx_cmd.memory_address_field;
                        d.hv_cmd = q.hv_s;
                     end else begin
                        d.oe = 1'b0;
                        d.st = ST_LOCK;
                     end
                  end else if (q.cnt == BIT_ACK) begin
                     d.cnt = BIT_FIRST;
                     d.oe = 1'b0;
                     // steps carry no data byte; the next byte is a command again
                     if (q.cmd.operation_code_field == OP_WRITE) begin
                        d.st = ST_DATA;
                     end
                  end else begin
                     d.cnt = q.cnt + BIT_STEP;
                  end
               end
            end
            ST_DATA: begin
               if (rise_ev && (q.cnt != BIT_ACK)) begin
                  d.shreg = {q.shreg[6:0], lnk_q.bit_val};
               end else if (rise_ev) begin
                  wr_fire = 1'b1;
               end
               if (fall_ev) begin
                  if (q.cnt == BIT_LAST) begin
                     d.cnt = BIT_ACK;
                     d.oe = 1'b1;
                  end else if (q.cnt == BIT_ACK) begin
                     d.cnt = BIT_FIRST;
                     d.oe = 1'b0;
                     d.st = ST_CMD;
                  end else begin
                     d.cnt = q.cnt + BIT_STEP;
                  end
               end
            end
            ST_TX_HI, ST_TX_LO: begin
               // master nack ends the read; release and wait for stop or start
               if (rise_ev && (q.cnt == BIT_ACK) && lnk_q.bit_val) begin
                  d.st = ST_SKIP;
               end
               if (fall_ev) begin
                  if (q.cnt == BIT_LAST) begin
                     d.cnt = BIT_ACK;
                     d.oe = 1'b0;
                  end else if (q.cnt == BIT_ACK) begin
                     d.cnt = BIT_FIRST;
                     if (q.st == ST_TX_HI) begin
                        d.st = ST_TX_LO;
                        d.shreg = rd_word[7:0];
                     end else begin
                        // continuous read repeats the same location
                        d.st = ST_TX_HI;
                        d.shreg = {READ_HI_PAD, rd_word[8]};
                     end
                     d.oe = ~d.shreg[TX_MSB];
                  end else begin
                     d.cnt = q.cnt + BIT_STEP;
                     d.shreg = {q.shreg[6:0], 1'b0};
                     d.oe = ~q.shreg[6];
                  end
               end
            end
            ST_IDLE, ST_LOCK, ST_SKIP: begin
               // everything ignored until the next start
               d.oe = 1'b0;
            end
            default: begin
               d.st = ST_IDLE;
               d.oe = 1'b0;
            end
         endcase
      end
      // apply the accepted operation to the addressed location
      // storage is nine bits wide, so the tenth bit is never kept
      case (q.cmd.memory_address_field)
         ADDR_WIPER0: d.wip0 = wiper_next(q.wip0, inc_fire, dec_fire, wr_fire,
                                          wr_wiper, wmax);
         ADDR_WIPER1: d.wip1 = wiper_next(q.wip1, inc_fire, dec_fire, wr_fire,
                                          wr_wiper, wmax);
         ADDR_TERM: begin
            if (wr_fire) begin
               d.term = wr_raw;
            end
         end
         default: d.term = q.term; // nothing else is stored
      endcase
   end

   // core register
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         q <= CORE_RESET;
      end else begin
         q <= d;
      end
   end

   // outputs
   assign sda_out = 1'b0;
   assign sda_oe_out = q.oe;
   assign wiper_zero_setting_out = q.wip0;
   assign wiper_one_setting_out = q.wip1;
   assign terminal_connection_control_out = q.term;
   assign high_voltage_active_out = q.hv_s;
   assign hv_command_out = q.hv_cmd;
   assign error_lockout_out = (q.st == ST_LOCK);

   // checks on the core domain
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (reset_in);

   a_ack_valid_cmd: assert property (cmd_done && cmd_ok |=> sda_oe_out)
      else $error("valid command not acknowledged");
   a_nack_bad_cmd: assert property (cmd_done && !cmd_ok |=> !sda_oe_out && error_lockout_out)
      else $error("invalid command acknowledged or not locked");
   a_lock_hold_start: assert property (error_lockout_out && !start_ev |=> error_lockout_out)
      else $error("lockout left without start");
   a_lock_no_change: assert property (error_lockout_out |=> $stable(q.wip0) && $stable(q.wip1))
      else $error("wiper changed during lockout");
   a_inc_one_step: assert property (inc_fire && (q.cmd.memory_address_field == ADDR_WIPER0)
      && (q.wip0 < wmax) |=> q.wip0 == $past(q.wip0) + WIPER_ONE)
      else $error("increment did not add one");
   a_inc_saturate: assert property (inc_fire && (q.wip0 >= wmax)
      && (q.cmd.memory_address_field == ADDR_WIPER0) |=> $stable(q.wip0))
      else $error("increment passed full scale");
   a_dec_saturate: assert property (dec_fire && (q.wip1 == WIPER_ZERO)
      && (q.cmd.memory_address_field == ADDR_WIPER1) |=> q.wip1 == WIPER_ZERO)
      else $error("decrement passed zero");
   a_write_value: assert property (wr_fire && (q.cmd.memory_address_field == ADDR_WIPER0)
      |=> q.wip0 == $past(wr_wiper))
      else $error("write value not stored");
   a_abort_keep: assert property ((q.st == ST_DATA) && stop_ev
      |=> $stable(q.wip0) && $stable(q.wip1) && $stable(q.term) ##1 (q.st == ST_IDLE))
      else $error("aborted write changed a location");
   a_stop_keep_ptr: assert property (stop_ev |=> $stable(q.ptr))
      else $error("pointer lost at stop");
   a_read_hi_pad: assert property ($rose(q.st == ST_TX_HI) |-> q.shreg[7:1] == READ_HI_PAD)
      else $error("high read byte has stray bits");

endmodule

// ===== sim/pwcd_master.sv
// two-wire bus master model facing the decoder
`timescale 1ns/1ps
module pwcd_master (
   input wire logic mclk_in, // paces the bit timing
   input wire logic sda_in, // resolved data wire
   output logic scl_out, // serial clock, high when idle
   output logic pull_out // high while pulling data low
);
   initial begin
      scl_out = 1'b1; // idle bus, clock stands still
      pull_out = 1'b0;
   end
   // whole core cycles, so changes land off the sampling edge
   task automatic tw(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   // start or repeated start: data falls while clock high
   task automatic start();
      pull_out = 1'b0;
      tw(8);
      scl_out = 1'b1;
      tw(16);
      pull_out = 1'b1;
      tw(16);
      scl_out = 1'b0;
   endtask
   // stop: data rises while clock high
   task automatic stop();
      tw(4);
      pull_out = 1'b1;
      tw(12);
      scl_out = 1'b1;
      tw(16);
      pull_out = 1'b0;
      tw(16);
   endtask
   // one pulse, data set while clock low, wire sampled mid-high
   task automatic bit_c(input logic drv_low, output logic seen);
      tw(4);
      pull_out = drv_low;
      tw(12);
      scl_out = 1'b1;
      tw(8);
      seen = sda_in;
      tw(8);
      scl_out = 1'b0;
   endtask
   // first n bits msb first; n below 8 cuts the byte short
   task automatic bits(input logic [7:0] b, input int n);
      logic s;
      for (int i = 7; i > 7 - n; i--) begin
         bit_c(~b[i], s);
      end
   endtask
   // whole byte, then the device's acknowledge slot
   task automatic tx(input logic [7:0] b, output logic ack);
      logic s;
      bits(b, 8);
      bit_c(1'b0, s);
      ack = ~s;
   endtask
   // byte from the device, then our ack or nack
   task automatic rx(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b0, b[i]);
      end
      bit_c(ack, s);
   endtask
endmodule

// ===== sim/pwcd_decoder_bench.sv
// self-checking bench for the wiper command decoder
`timescale 1ns/1ps
module pwcd_decoder_bench;
   import pwcd_pkg::*;
   localparam logic [7:0] CTRL_W = 8'h5c; // address 17h, strap low, write
   localparam logic [7:0] CTRL_R = 8'h5d; // same address, read
   logic mclk, rst, scl, pull, sda_o, sda_oe, hv, hv_act, hv_cmd, lock;
   logic [8:0] w0, w1, term;
   logic [7:0] hi, lo;
   wire logic sda = ~(pull | (sda_oe & ~sda_o)); // pulled-up open drain wire
   int err_count = 0;
   int n_checks = 0;
   pwcd_decoder #(.STEPS_257(1'b1), .SLAVE_ADDR_HI(6'h17), .WIPER_RESET(9'h080),
      .TERM_RESET(9'h1ff)) dut (.mclk_in(mclk), .reset_in(rst), .link_scl_clk_in(scl),
      .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .lowest_address_select_in(1'b0),
      .high_voltage_indicator_in(hv), .wiper_zero_setting_out(w0),
      .wiper_one_setting_out(w1), .terminal_connection_control_out(term),
      .high_voltage_active_out(hv_act), .hv_command_out(hv_cmd), .error_lockout_out(lock));
   pwcd_master m (.mclk_in(mclk), .sda_in(sda), .scl_out(scl), .pull_out(pull));
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (err_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // spare bit always set: it must change nothing
   function automatic logic [7:0] cb(input logic [3:0] a, input pwcd_op_t o, input logic d);
      return {a, o, 1'b1, d};
   endfunction
   task automatic xb(input logic [7:0] b, input logic exp_ack);
      logic a;
      m.tx(b, a);
      check({8'h00, a}, {8'h00, exp_ack});
   endtask
   task automatic open_w();
      m.start();
      xb(CTRL_W, 1'b1);
   endtask
   task automatic wp(input logic [3:0] a, input logic [8:0] v);
      xb(cb(a, OP_WRITE, v[8]), 1'b1);
      xb(v[7:0], 1'b1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [8:0] v);
      open_w();
      xb(cb(a, OP_READ, 1'b0), 1'b1);
      m.start();
      xb(CTRL_R, 1'b1);
      m.rx(1'b1, hi);
      m.rx(1'b0, lo);
      m.stop();
      check({1'b0, hi}, {8'h00, v[8]});
      check({1'b0, lo}, {1'b0, v[7:0]});
   endtask
   // continuous pairs to all three volatile places, wipers read back
   task automatic t_write();
      open_w();
      wp(4'h0, 9'h100);
      wp(4'h1, 9'h0ff);
      wp(4'h4, 9'h055);
      m.stop();
      check(w0, 9'h100);
      check(term, 9'h055);
      rd(4'h0, 9'h100);
      rd(4'h1, 9'h0ff);
   endtask
   // saturation at both ends, two steps to each limit, the second one past it
   task automatic t_incdec();
      open_w();
      wp(4'h0, 9'h0ff);
      xb(cb(4'h0, OP_INC, 1'b0), 1'b1);
      xb(cb(4'h0, OP_INC, 1'b0), 1'b1);
      wp(4'h1, 9'h001);
      xb(cb(4'h1, OP_DEC, 1'b0), 1'b1);
      xb(cb(4'h1, OP_DEC, 1'b0), 1'b1);
      m.stop();
      check(w0, 9'h100);
      check(w1, 9'h000);
   endtask
   // stop three bits into a data byte leaves the wiper alone
   task automatic t_abort();
      open_w();
      xb(cb(4'h1, OP_WRITE, 1'b1), 1'b1);
      m.bits(8'h5a, 3);
      m.stop();
      check(w1, 9'h000);
   endtask
   // every non-wiper address refuses a step; only a start recovers
   task automatic t_lock();
      for (int a = 2; a < 16; a++) begin
         open_w();
         xb(cb(a[3:0], a[0] ? OP_INC : OP_DEC, 1'b0), 1'b0);
         m.stop();
         check({8'h00, lock}, 9'h001);
      end
      open_w();
      wp(4'h4, 9'h1aa);
      m.stop();
      check(term, 9'h1aa);
      check({8'h00, lock}, 9'h000);
   endtask
   // high voltage level followed, recorded by a step and shown in the status word
   task automatic t_hv();
      hv = 1'b1;
      open_w();
      xb(cb(4'h1, OP_INC, 1'b0), 1'b1);
      m.stop();
      check({8'h00, hv_act}, 9'h001);
      check({8'h00, hv_cmd}, 9'h001);
      check(w1, 9'h001);
      rd(4'h5, 9'h003);
      hv = 1'b0;
      repeat (4) @(negedge mclk);
      check({8'h00, hv_act}, 9'h000);
   endtask
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // long enough for all traffic at about 290 cycles a byte
   initial begin
      repeat (60000) @(posedge mclk);
      err_count++;
      give_verdict();
   end
   initial begin
      rst = 1'b1;
      hv = 1'b0;
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      repeat (12) @(negedge mclk);
      check(w0, 9'h080);
      check(term, 9'h1ff);
      t_write();
      t_incdec();
      t_abort();
      t_lock();
      t_hv();
      give_verdict();
   end
endmodule
